// ### test/link_partner_model.sv
// Behavioural far-side link partner for lane status and ordered sets
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
	input wire logic mclk,
	output logic [3:0] lane_sync,
	output logic lanes_aligned,
	output logic block_lock,
	output logic high_ber,
	output logic oset_valid,
	output logic oset_is_fault,
	output logic [31:0] oset_data
);
	initial begin
		{lane_sync, lanes_aligned, block_lock, high_ber} = 7'h0;
		{oset_valid, oset_is_fault} = 2'h0;
		oset_data = 32'hFFFFFFFF;
	end
	task automatic set_link(input logic [3:0] s, input logic al, input logic bl, input logic hb);
		@(posedge mclk);
		lane_sync <= s;
		lanes_aligned <= al;
		block_lock <= bl;
		high_ber <= hb;
	endtask
	task automatic send_oset(input logic flt, input logic [31:0] d);
		@(posedge mclk);
		oset_valid <= 1'h1;
		oset_is_fault <= flt;
		oset_data <= d;
		@(posedge mclk);
		oset_valid <= 1'h0;
		oset_is_fault <= ~flt;
		// Inverted after release so a late capture cannot match by luck
		oset_data <= ~d;
	endtask
endmodule
`default_nettype wire

// ### test/pcs_link_monitor_asserts.sv
// Port checker for the PCS link monitor
`timescale 1ns/1ps
`default_nettype none
module pcs_link_monitor_asserts (
	input wire mclk,
	input wire rst,
	input wire [5:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata_ff,
	input wire four_lane_data_ok_ff,
	input wire single_lane_data_ok_ff,
	input wire pcs_event_irq_ff,
	input wire [2:0] speed_sel_ff,
	input wire port_reset_ff
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence mode_wr;
		reg_wr && reg_addr == 6'h00;
	endsequence
	// Path outputs lag the speed field by two stages; the check accepts up to three
	property path_was(sig, code);
		sig |-> $past(speed_sel_ff) == code || $past(speed_sel_ff, 2) == code
			|| $past(speed_sel_ff, 3) == code;
	endproperty
	speed_load_a: assert property (mode_wr |=> speed_sel_ff == $past(reg_wdata[2:0])
		&& port_reset_ff == $past(reg_wdata[4])) else $error("mode field not loaded");
	speed_hold_a: assert property (!(reg_wr && reg_addr == 6'h00) |=> $stable(speed_sel_ff))
		else $error("speed changed without write");
	rd_idle_a: assert property (!reg_rd |=> reg_rdata_ff == 32'h0)
		else $error("read data outside read slot");
	unmapped_rd_a: assert property (reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata_ff == 32'h0)
		else $error("unmapped read not zero");
	four_path_a: assert property (path_was(four_lane_data_ok_ff, 3'h4))
		else $error("four lane ok outside four lane path");
	single_path_a: assert property (path_was(single_lane_data_ok_ff, 3'h7))
		else $error("single lane ok outside single path");
	irq_path_a: assert property (path_was(pcs_event_irq_ff, 3'h7))
		else $error("interrupt from unselected path");
	reset_vals_a: assert property (disable iff (1'h0) rst |-> speed_sel_ff == 3'h6
		&& port_reset_ff && !pcs_event_irq_ff) else $error("reset values wrong");
endmodule
bind pcs_link_monitor pcs_link_monitor_asserts i_chk (.mclk, .rst, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata_ff, .four_lane_data_ok_ff, .single_lane_data_ok_ff,
	.pcs_event_irq_ff, .speed_sel_ff, .port_reset_ff);
`default_nettype wire

// ### test/pcs_link_monitor_tb.sv
// Self-checking bench for the PCS link monitor
`timescale 1ns/1ps
`default_nettype none
module pcs_link_monitor_tb;
	logic mclk, rst, reg_wr, reg_rd;
	logic [5:0] reg_addr;
	logic [31:0] reg_wdata;
	logic [3:0] lane_active;
	logic [9:0] ev;
	int n_fail, samples_checked, cyc;
	wire [31:0] reg_rdata_ff, oset_data;
	wire [3:0] lane_sync;
	wire four_lane_data_ok_ff, single_lane_data_ok_ff, pcs_event_irq_ff;
	wire lanes_aligned, block_lock, high_ber, oset_valid, oset_is_fault;
	link_partner_model i_peer (.mclk, .lane_sync, .lanes_aligned, .block_lock, .high_ber,
		.oset_valid, .oset_is_fault, .oset_data);
	pcs_link_monitor i_dut (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata_ff, .lane_active, .lane_sync, .lane_local_fault({1'h0, ev[9], 2'h0}),
		.lane_code_err({3'h0, ev[5]}), .lane_disparity_err({3'h0, ev[6]}),
		.lane_fifo_overflow({3'h0, ev[7]}), .lane_fifo_underflow({3'h0, ev[8]}),
		.lanes_aligned, .block_lock, .high_ber, .oset_valid, .oset_is_fault, .oset_data,
		.tx_enter_error(ev[0]), .tx_bad_char(ev[1]), .rx_enter_bad_header(ev[2]),
		.rx_enter_error(ev[3]), .rx_bad_char(ev[4]), .four_lane_data_ok_ff,
		.single_lane_data_ok_ff, .pcs_event_irq_ff, .speed_sel_ff(), .port_reset_ff());
	initial begin
		mclk = 1'h0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Run is dominated by the saturation fill, so the ceiling sits well above it
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 90000) begin
			n_fail++;
			report_and_stop();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'h0;
	endtask
	task automatic rdc(input logic [5:0] a, input logic [31:0] e);
		@(posedge mclk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'h0;
		#1;
		chk($sformatf("reg %h", a), reg_rdata_ff, e);
	endtask
	task automatic pulse(input int i, input int n);
		repeat (n) begin
			@(posedge mclk);
			ev[i] <= 1'h1;
			@(posedge mclk);
			ev[i] <= 1'h0;
		end
	endtask
	task automatic t_reset();
		rdc(6'h00, 32'h16);
		rdc(6'h14, 32'h0);
		rdc(6'h06, 32'h0);
	endtask
	task automatic t_single();
		wr(6'h00, 32'h7);
		i_peer.set_link(4'hF, 1'h1, 1'h1, 1'h0);
		idle(6);
		chk("single ok", single_lane_data_ok_ff, 32'h1);
		rdc(6'h0C, 32'h1);
		rdc(6'h04, 32'h0);
		rdc(6'h10, 32'h1);
		wr(6'h14, 32'h1);
		idle(2);
		chk("irq", pcs_event_irq_ff, 32'h1);
		wr(6'h10, 32'h1);
		idle(2);
		rdc(6'h10, 32'h0);
		chk("irq", pcs_event_irq_ff, 32'h0);
		i_peer.set_link(4'hF, 1'h1, 1'h0, 1'h1);
		idle(6);
		rdc(6'h0C, 32'h2);
		rdc(6'h10, 32'h3);
		i_peer.send_oset(1'h1, 32'hA5A50001);
		i_peer.send_oset(1'h0, 32'h00005A02);
		idle(3);
		rdc(6'h1C, 32'h2);
		rdc(6'h10, 32'h7);
		rdc(6'h18, 32'hA5A50001);
		rdc(6'h18, 32'h00005A02);
		rdc(6'h1C, 32'h0);
		for (int i = 0; i < 5; i++) begin
			pulse(i, i + 1);
			idle(2);
			rdc(6'(32 + 4 * i), 32'(i + 1));
		end
	endtask
	task automatic t_four();
		i_peer.set_link(4'hF, 1'h1, 1'h0, 1'h0);
		idle(4);
		wr(6'h00, 32'h4);
		idle(6);
		chk("four ok", four_lane_data_ok_ff, 32'h1);
		rdc(6'h08, 32'h0);
		pulse(9, 1);
		pulse(5, 2);
		idle(2);
		rdc(6'h04, 32'h000F0401);
		rdc(6'h08, 32'h4);
		chk("irq", pcs_event_irq_ff, 32'h0);
		pulse(7, 2);
		pulse(8, 3);
		pulse(6, 1);
		idle(2);
		rdc(6'h34, 32'h2);
		rdc(6'h38, 32'h3);
		rdc(6'h3C, 32'h00020001);
		i_peer.set_link(4'hE, 1'h0, 1'h0, 1'h0);
		idle(6);
		rdc(6'h08, 32'h7);
		chk("four ok", four_lane_data_ok_ff, 32'h0);
		i_peer.set_link(4'hF, 1'h1, 1'h0, 1'h0);
		idle(6);
		wr(6'h08, 32'h7);
		wr(6'h04, 32'h00000F00);
		idle(2);
		rdc(6'h08, 32'h0);
		rdc(6'h04, 32'h000F0001);
		// Lane 2 leaves the active set: its fault and sync loss must not register
		@(posedge mclk);
		lane_active <= 4'hB;
		pulse(9, 1);
		i_peer.set_link(4'hB, 1'h1, 1'h0, 1'h0);
		idle(6);
		rdc(6'h04, 32'h000B0001);
		rdc(6'h08, 32'h0);
	endtask
	task automatic t_sat();
		@(posedge mclk);
		ev[7] <= 1'h1;
		repeat (65540) @(posedge mclk);
		ev[7] <= 1'h0;
		idle(2);
		rdc(6'h34, 32'hFFFF);
		wr(6'h00, 32'h14);
		rdc(6'h34, 32'h0);
	endtask
	initial begin
		rst = 1'h0;
		{reg_wr, reg_rd, reg_addr, reg_wdata, ev} = '0;
		lane_active = 4'hF;
		// Raised after time zero so the design's reset branch cannot miss the edge
		#1 rst = 1'h1;
		repeat (10) @(posedge mclk);
		rst <= 1'h0;
		t_reset();
		t_single();
		t_four();
		t_sat();
		report_and_stop();
	end
endmodule
`default_nettype wire

// ### verilog/capture_fifo.v
// Small FIFO memory holding captured sequence ordered sets
`timescale 1ns/1ps
`default_nettype none
module capture_fifo #(
	parameter WIDTH = 32,
	parameter AW = 3
) (
	input wire mclk,
	input wire rst,
	input wire clear,
	input wire push,
	input wire [WIDTH-1:0] push_data,
	input wire pop,
	output reg [WIDTH-1:0] head_ff,
	output reg [AW:0] fill_ff
);
	reg [WIDTH-1:0] mem [0:(1<<AW)-1];
	reg [AW-1:0] wr_ff;
	reg [AW-1:0] rd_ff;
	wire full = fill_ff[AW];
	wire empty = (fill_ff == {(AW+1){1'b0}});
	wire do_push = push && !full;
	wire do_pop = pop && !empty;
	always @(posedge mclk) begin
		if (do_push) begin
			mem[wr_ff] <= push_data;
		end
	end
	// Head is registered; shown value is the oldest entry, zero when empty
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			wr_ff <= {AW{1'b0}};
			rd_ff <= {AW{1'b0}};
			fill_ff <= {(AW+1){1'b0}};
			head_ff <= {WIDTH{1'b0}};
		end else if (clear) begin
			wr_ff <= {AW{1'b0}};
			rd_ff <= {AW{1'b0}};
			fill_ff <= {(AW+1){1'b0}};
			head_ff <= {WIDTH{1'b0}};
		end else begin
			if (do_push) begin
				wr_ff <= wr_ff + {{(AW-1){1'b0}}, 1'b1};
			end
			if (do_pop) begin
				rd_ff <= rd_ff + {{(AW-1){1'b0}}, 1'b1};
			end
			if (do_push && !do_pop) begin
				fill_ff <= fill_ff + {{AW{1'b0}}, 1'b1};
			end else if (do_pop && !do_push) begin
				fill_ff <= fill_ff - {{AW{1'b0}}, 1'b1};
			end
			if (empty && do_push) begin
				head_ff <= push_data;
			end else if (do_pop && (fill_ff == {{AW{1'b0}}, 1'b1}) && !do_push) begin
				head_ff <= {WIDTH{1'b0}};
			end else if (do_pop && (fill_ff == {{AW{1'b0}}, 1'b1})) begin
				head_ff <= push_data;
			end else if (do_pop) begin
				head_ff <= mem[rd_ff + {{(AW-1){1'b0}}, 1'b1}];
			end
		end
	end
endmodule
`default_nettype wire

// ### verilog/pcs_link_monitor.v
// Link surveillance and error accounting for a dual-path 10G port PCS
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_monitor_regs.vh"
module pcs_link_monitor #(
	parameter LANES = 4,
	parameter CNT_W = 16,
	parameter OSET_W = 32,
	parameter FIFO_AW = 3
) (
	input wire mclk,
	input wire rst,
	input wire [`ADDR_W-1:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata_ff,
	input wire [LANES-1:0] lane_active,
	input wire [LANES-1:0] lane_sync,
	input wire [LANES-1:0] lane_local_fault,
	input wire [LANES-1:0] lane_code_err,
	input wire [LANES-1:0] lane_disparity_err,
	input wire [LANES-1:0] lane_fifo_overflow,
	input wire [LANES-1:0] lane_fifo_underflow,
	input wire lanes_aligned,
	input wire block_lock,
	input wire high_ber,
	input wire oset_valid,
	input wire oset_is_fault,
	input wire [OSET_W-1:0] oset_data,
	input wire tx_enter_error,
	input wire tx_bad_char,
	input wire rx_enter_bad_header,
	input wire rx_enter_error,
	input wire rx_bad_char,
	output reg four_lane_data_ok_ff,
	output reg single_lane_data_ok_ff,
	output reg pcs_event_irq_ff,
	output reg [2:0] speed_sel_ff,
	output reg port_reset_ff
);
	// One-hot path states decoded from the speed select
	localparam PATH_OFF = 3'b001;
	localparam PATH_FOUR = 3'b010;
	localparam PATH_ONE = 3'b100;

	reg [2:0] path_ff;
	reg [2:0] nxt_path;
	reg [LANES-1:0] lane_fault_seen_ff;
	reg [2:0] four_lane_err_ff;
	reg [2:0] single_lane_event_ff;
	reg [2:0] single_lane_event_mask_ff;
	reg lanes_aligned_q_ff;
	reg block_lock_q_ff;
	wire [OSET_W-1:0] fault_sequence_capture_word;
	reg [31:0] rd_mux;

	// Two-stage synchronisers for status arriving from the line-side clocks
	reg [LANES-1:0] sync_a_ff;
	reg [LANES-1:0] sync_b_ff;
	reg align_a_ff;
	reg align_b_ff;
	reg lock_a_ff;
	reg lock_b_ff;
	reg ber_a_ff;
	reg ber_b_ff;
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			sync_a_ff <= {LANES{1'b0}};
			sync_b_ff <= {LANES{1'b0}};
			align_a_ff <= 1'b0;
			align_b_ff <= 1'b0;
			lock_a_ff <= 1'b0;
			lock_b_ff <= 1'b0;
			ber_a_ff <= 1'b0;
			ber_b_ff <= 1'b0;
		end else begin
			sync_a_ff <= lane_sync;
			sync_b_ff <= sync_a_ff;
			align_a_ff <= lanes_aligned;
			align_b_ff <= align_a_ff;
			lock_a_ff <= block_lock;
			lock_b_ff <= lock_a_ff;
			ber_a_ff <= high_ber;
			ber_b_ff <= ber_a_ff;
		end
	end

	// Register address match, shared by every write decode and the capture-word read hit
	function addr_is;
		input [`ADDR_W-1:0] a;
		input [`ADDR_W-1:0] r;
		begin
			addr_is = (a == r);
		end
	endfunction

	wire wr_hit_ctrl = reg_wr && addr_is(reg_addr, `REG_MODE_CTRL);
	wire wr_hit_ferr = reg_wr && addr_is(reg_addr, `REG_FOUR_LANE_ERR);
	wire wr_hit_fstate = reg_wr && addr_is(reg_addr, `REG_FOUR_LANE_STATE);
	wire wr_hit_evt = reg_wr && addr_is(reg_addr, `REG_ONE_LANE_EVENT);
	wire wr_hit_mask = reg_wr && addr_is(reg_addr, `REG_ONE_LANE_MASK);
	wire rd_hit_capture = reg_rd && addr_is(reg_addr, `REG_CAPTURE_WORD);
	// Write-one-to-clear masks; zero when the write is aimed elsewhere
	wire [LANES-1:0] fault_clr = wr_hit_fstate ? reg_wdata[LANES+7:8] : {LANES{1'b0}};
	wire [2:0] ferr_clr = wr_hit_ferr ? reg_wdata[2:0] : 3'h0;
	wire [2:0] evt_clr = wr_hit_evt ? reg_wdata[2:0] : 3'h0;

	// Speed select decode; reserved codes leave both paths idle
	always @* begin
		case (speed_sel_ff)
			`SPEED_FOUR_LANE: nxt_path = PATH_FOUR;
			`SPEED_ONE_LANE: nxt_path = PATH_ONE;
			default: nxt_path = PATH_OFF;
		endcase
	end
	wire four_on = path_ff[1];
	wire one_on = path_ff[2];

	// Only inputs of the selected path may change its status; a wrong config
	// with both paths active cannot occur since one code selects one path
	wire [LANES-1:0] sync_lost_lane = lane_active & ~sync_b_ff;
	wire sync_lost_ev = four_on && (|sync_lost_lane);
	wire align_lost_ev = four_on && lanes_aligned_q_ff && !align_b_ff;
	wire code_err_ev = four_on && (|(lane_code_err & lane_active));
	wire lock_change_ev = one_on && (lock_b_ff != block_lock_q_ff);
	wire high_ber_ev = one_on && ber_b_ff;
	wire fault_seq_ev = one_on && oset_valid && oset_is_fault;
	wire [2:0] four_set = {code_err_ev, align_lost_ev, sync_lost_ev};
	wire [2:0] one_set = {fault_seq_ev, high_ber_ev, lock_change_ev};
	wire [LANES-1:0] lane_fault_set = four_on ? (lane_local_fault & lane_active) : {LANES{1'b0}};

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			speed_sel_ff <= `SPEED_RESET;
			port_reset_ff <= 1'b1;
			path_ff <= PATH_OFF;
			lane_fault_seen_ff <= {LANES{1'b0}};
			four_lane_err_ff <= 3'h0;
			single_lane_event_ff <= 3'h0;
			single_lane_event_mask_ff <= `MASK_RESET;
			lanes_aligned_q_ff <= 1'b0;
			block_lock_q_ff <= 1'b0;
			four_lane_data_ok_ff <= 1'b0;
			single_lane_data_ok_ff <= 1'b0;
			pcs_event_irq_ff <= 1'b0;
		end else begin
			if (wr_hit_ctrl) begin
				speed_sel_ff <= reg_wdata[2:0];
				port_reset_ff <= reg_wdata[4];
			end
			path_ff <= nxt_path;
			lanes_aligned_q_ff <= align_b_ff;
			block_lock_q_ff <= lock_b_ff;
			// Set wins over a same-cycle write-one clear
			lane_fault_seen_ff <= (lane_fault_seen_ff & ~fault_clr) | lane_fault_set;
			four_lane_err_ff <= (four_lane_err_ff & ~ferr_clr) | four_set;
			single_lane_event_ff <= (single_lane_event_ff & ~evt_clr) | one_set;
			if (wr_hit_mask) begin
				single_lane_event_mask_ff <= reg_wdata[2:0];
			end
			four_lane_data_ok_ff <= four_on && align_b_ff;
			single_lane_data_ok_ff <= one_on && lock_b_ff;
			// Interrupt follows the masked single-lane sticky bits, only while the single-lane path is selected
			pcs_event_irq_ff <= one_on && (|(single_lane_event_ff & single_lane_event_mask_ff));
		end
	end

	// Capture FIFO: each received sequence ordered set on the single-lane path while fewer than eight are held
	wire [FIFO_AW:0] signal_set_capture_fill;
	capture_fifo #(
		.WIDTH(OSET_W),
		.AW(FIFO_AW)
	) u_capture (
		.mclk(mclk),
		.rst(rst),
		.clear(port_reset_ff),
		.push(one_on && oset_valid),
		.push_data(oset_data),
		.pop(rd_hit_capture),
		.head_ff(fault_sequence_capture_word),
		.fill_ff(signal_set_capture_fill)
	);

	// Counters, all saturating and cleared while the port reset bit is set
	wire [8:0] cnt_event;
	wire [CNT_W-1:0] cnt_val [0:8];
	assign cnt_event[0] = one_on && tx_enter_error;
	assign cnt_event[1] = one_on && tx_bad_char;
	assign cnt_event[2] = one_on && rx_enter_bad_header;
	assign cnt_event[3] = one_on && rx_enter_error;
	assign cnt_event[4] = one_on && rx_bad_char;
	assign cnt_event[5] = four_on && (|(lane_fifo_overflow & lane_active));
	assign cnt_event[6] = four_on && (|(lane_fifo_underflow & lane_active));
	assign cnt_event[7] = four_on && (|(lane_disparity_err & lane_active));
	assign cnt_event[8] = four_on && (|(lane_code_err & lane_active));
	genvar gi;
	generate
		for (gi = 0; gi < 9; gi = gi + 1) begin : g_cnt
			sat_counter #(
				.WIDTH(CNT_W)
			) u_cnt (
				.mclk(mclk),
				.rst(rst),
				.clear(port_reset_ff),
				.event_in(cnt_event[gi]),
				.count_ff(cnt_val[gi])
			);
		end
	endgenerate

	function [31:0] widen_cnt;
		input [CNT_W-1:0] v;
		begin
			widen_cnt = 32'h0;
			widen_cnt[CNT_W-1:0] = v;
		end
	endfunction

	// Read mux; the disparity and code-group counts share one word, high half code-group
	always @* begin
		rd_mux = 32'h0;
		case (reg_addr)
			`REG_MODE_CTRL: rd_mux = {27'h0, port_reset_ff, 1'b0, speed_sel_ff};
			`REG_FOUR_LANE_STATE: begin
				rd_mux[0] = four_on && align_b_ff;
				rd_mux[LANES+7:8] = lane_fault_seen_ff;
				// Lane sync belongs to the four-lane path and reads zero outside it
				rd_mux[LANES+15:16] = four_on ? sync_b_ff : {LANES{1'b0}};
			end
			`REG_FOUR_LANE_ERR: rd_mux = {29'h0, four_lane_err_ff};
			`REG_ONE_LANE_STATE: rd_mux = {30'h0, one_on && ber_b_ff, one_on && lock_b_ff};
			`REG_ONE_LANE_EVENT: rd_mux = {29'h0, single_lane_event_ff};
			`REG_ONE_LANE_MASK: rd_mux = {29'h0, single_lane_event_mask_ff};
			`REG_CAPTURE_WORD: rd_mux[OSET_W-1:0] = fault_sequence_capture_word;
			`REG_CAPTURE_FILL: rd_mux[FIFO_AW:0] = signal_set_capture_fill;
			`REG_TX_ERR_ENTRIES: rd_mux = widen_cnt(cnt_val[0]);
			`REG_TX_BAD_CHAR: rd_mux = widen_cnt(cnt_val[1]);
			`REG_RX_BAD_HDR_ENTRIES: rd_mux = widen_cnt(cnt_val[2]);
			`REG_RX_ERR_ENTRIES: rd_mux = widen_cnt(cnt_val[3]);
			`REG_RX_BAD_CHAR: rd_mux = widen_cnt(cnt_val[4]);
			`REG_LANE_OVERFLOW: rd_mux = widen_cnt(cnt_val[5]);
			`REG_LANE_UNDERFLOW: rd_mux = widen_cnt(cnt_val[6]);
			`REG_LANE_DISPARITY: rd_mux = {cnt_val[8], cnt_val[7]};
			default: rd_mux = 32'h0;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			reg_rdata_ff <= 32'h0;
		end else if (reg_rd) begin
			reg_rdata_ff <= rd_mux;
		end else begin
			reg_rdata_ff <= 32'h0;
		end
	end
endmodule
`default_nettype wire

// ### verilog/pcs_monitor_regs.vh
// Register offsets, field positions, reset values and mode codes for the PCS link monitor
`ifndef PCS_MONITOR_REGS_VH
`define PCS_MONITOR_REGS_VH
`define ADDR_W 6
`define REG_MODE_CTRL 6'h00
`define REG_FOUR_LANE_STATE 6'h04
`define REG_FOUR_LANE_ERR 6'h08
`define REG_ONE_LANE_STATE 6'h0C
`define REG_ONE_LANE_EVENT 6'h10
`define REG_ONE_LANE_MASK 6'h14
`define REG_CAPTURE_WORD 6'h18
`define REG_CAPTURE_FILL 6'h1C
`define REG_TX_ERR_ENTRIES 6'h20
`define REG_TX_BAD_CHAR 6'h24
`define REG_RX_BAD_HDR_ENTRIES 6'h28
`define REG_RX_ERR_ENTRIES 6'h2C
`define REG_RX_BAD_CHAR 6'h30
`define REG_LANE_OVERFLOW 6'h34
`define REG_LANE_UNDERFLOW 6'h38
`define REG_LANE_DISPARITY 6'h3C
`define SPEED_FOUR_LANE 3'h4
`define SPEED_CLOCKS_OFF 3'h6
`define SPEED_ONE_LANE 3'h7
`define SPEED_RESET 3'h6
`define ERR_SYNC_LOST_BIT 0
`define ERR_ALIGN_LOST_BIT 1
`define ERR_CODEWORD_BIT 2
`define EVT_LOCK_CHANGE_BIT 0
`define EVT_HIGH_BER_BIT 1
`define EVT_FAULT_SEQ_BIT 2
`define MASK_RESET 3'h0
`define CODEGROUP_OFFSET 6'h00
`endif

// ### verilog/sat_counter.v
// Saturating event counter that is cleared by the port reset
`timescale 1ns/1ps
`default_nettype none
module sat_counter #(
	parameter WIDTH = 16
) (
	input wire mclk,
	input wire rst,
	input wire clear,
	input wire event_in,
	output reg [WIDTH-1:0] count_ff
);
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			count_ff <= {WIDTH{1'b0}};
		end else if (clear) begin
			count_ff <= {WIDTH{1'b0}};
		end else if (event_in && (count_ff != {WIDTH{1'b1}})) begin
			count_ff <= count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
endmodule
`default_nettype wire
